// ### msc_pkg.sv
package msc_pkg;
	// Register indexes and byte addresses
	localparam int          MSC_ADDR_W           = 20;
	localparam logic [15:0] MSC_IDX_MODE_STATUS  = 16'hFFF1;
	localparam logic [15:0] MSC_IDX_SYS_CTRL     = 16'hFFF2;
	localparam logic [19:0] MSC_ADDR_MODE_STATUS = {2'b00, MSC_IDX_MODE_STATUS, 2'b00};
	localparam logic [19:0] MSC_ADDR_SYS_CTRL    = {2'b00, MSC_IDX_SYS_CTRL, 2'b00};
	// System control fields
	localparam int          MSC_SC_STANDBY_BIT   = 7;
	localparam int          MSC_SC_SETTLE_HI     = 6;
	localparam int          MSC_SC_SETTLE_LO     = 4;
	localparam int          MSC_SC_USER_EN_BIT   = 3;
	localparam int          MSC_SC_NMI_EDGE_BIT  = 2;
	localparam int          MSC_SC_RSVD_BIT      = 1;
	localparam int          MSC_SC_RAM_BIT       = 0;
	localparam logic [7:0]  MSC_SC_RESET         = 8'h0B;
	localparam logic [7:0]  MSC_SC_WR_MASK       = 8'hFD;
	// Mode status fixed bits
	localparam logic [7:0]  MSC_MS_FIXED         = 8'hC0;
	// Address pin enables per mode
	localparam logic [23:0] MSC_PINS_1M          = 24'h0FFFFF;
	localparam logic [23:0] MSC_PINS_16M         = 24'hFFFFFF;
	// Settling waits in states (clock cycles)
	localparam int          MSC_SETTLE_0         = 8192;
	localparam int          MSC_SETTLE_1         = 16384;
	localparam int          MSC_SETTLE_2         = 32768;
	localparam int          MSC_SETTLE_3         = 65536;
	localparam int          MSC_SETTLE_4         = 131072;
	localparam int          MSC_CNT_W            = 18;
	// Bus responses
	localparam logic [1:0]  MSC_RESP_OKAY        = 2'b00;
	localparam logic [1:0]  MSC_RESP_SLVERR      = 2'b10;
	// Power state, one-hot
	typedef enum logic [3:0] {
		MSC_RUN     = 4'b0001,
		MSC_SLEEP   = 4'b0010,
		MSC_STANDBY = 4'b0100,
		MSC_SETTLE  = 4'b1000
	} msc_pwr_t;
endpackage

// ### msc_settle_timer.sv
`timescale 1ns/1ps
module msc_settle_timer import msc_pkg::*; #(
	parameter int unsigned CNT0 = MSC_SETTLE_0,
	parameter int unsigned CNT1 = MSC_SETTLE_1,
	parameter int unsigned CNT2 = MSC_SETTLE_2,
	parameter int unsigned CNT3 = MSC_SETTLE_3,
	parameter int unsigned CNT4 = MSC_SETTLE_4
) (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       start,
	input  wire logic [2:0] sel,
	output logic            done
);
	logic [MSC_CNT_W-1:0] cnt_reg;
	logic                 busy_reg;

	// Wait length minus one for the selected setting
	function automatic logic [MSC_CNT_W-1:0] load_val(input logic [2:0] s);
		logic [MSC_CNT_W-1:0] v;
		case (s)
			3'h0: v = MSC_CNT_W'(CNT0 - 1);
			3'h1: v = MSC_CNT_W'(CNT1 - 1);
			3'h2: v = MSC_CNT_W'(CNT2 - 1);
			3'h3: v = MSC_CNT_W'(CNT3 - 1);
			default: v = MSC_CNT_W'(CNT4 - 1); // 10x, and 11x held the same
		endcase
		return v;
	endfunction

	// Count down, pulse done when the wait ends
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_reg  <= '0;
			busy_reg <= 1'b0;
			done     <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start) begin
				cnt_reg  <= load_val(sel);
				busy_reg <= 1'b1;
			end else if (busy_reg) begin
				if (cnt_reg == '0) begin
					busy_reg <= 1'b0;
					done     <= 1'b1;
				end else begin
					cnt_reg <= cnt_reg - 1'b1;
				end
			end
		end
	end
endmodule

// ### msc_top.sv
`timescale 1ns/1ps
module msc_top import msc_pkg::*; #(
	parameter int unsigned SETTLE_0 = MSC_SETTLE_0,
	parameter int unsigned SETTLE_1 = MSC_SETTLE_1,
	parameter int unsigned SETTLE_2 = MSC_SETTLE_2,
	parameter int unsigned SETTLE_3 = MSC_SETTLE_3,
	parameter int unsigned SETTLE_4 = MSC_SETTLE_4
) (
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic [MSC_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [MSC_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	input  wire logic                  mode_pin_high,
	input  wire logic                  mode_pin_low,
	input  wire logic                  nmi_pin,
	input  wire logic                  halt_insn,
	input  wire logic                  wake_irq,
	input  wire logic                  exc_start,
	output logic                       mode_16m,
	output logic [23:0]                addr_pin_en,
	output logic                       ram_map_en,
	output logic                       nmi_request,
	output logic                       user_flag_is_mask,
	output logic                       set_mask_flag,
	output logic                       set_user_flag,
	output logic                       sleep_active,
	output logic                       standby_active,
	output logic                       clock_settled
);
	logic [1:0]       mode_sync1_reg, mode_sync2_reg;
	logic [2:0]       nmi_sync_reg;
	logic [7:0]       sys_ctrl_reg;
	logic [MSC_ADDR_W-1:0] awaddr_reg;
	logic [7:0]       wdata_reg;
	logic             wstrb0_reg, aw_held_reg, w_held_reg;
	logic             wr_fire;
	msc_pwr_t         pwr_reg, pwr_next;
	logic             settle_start_reg, settle_done;

	// Mode pins through two flip-flops, nmi pin through three
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_sync1_reg <= 2'b00;
			mode_sync2_reg <= 2'b00;
			nmi_sync_reg   <= 3'b111;
		end else begin
			mode_sync1_reg <= {mode_pin_high, mode_pin_low};
			mode_sync2_reg <= mode_sync1_reg;
			nmi_sync_reg   <= {nmi_sync_reg[1:0], nmi_pin};
		end
	end

	// Mode decode and address pin enables
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_16m    <= 1'b0;
			addr_pin_en <= MSC_PINS_1M;
		end else begin
			mode_16m    <= &mode_sync2_reg;
			addr_pin_en <= (&mode_sync2_reg) ? MSC_PINS_16M : MSC_PINS_1M;
		end
	end

	// Write address and data latch in either order
	assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg   <= 1'b0;
			w_held_reg    <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			awaddr_reg    <= '0;
			wdata_reg     <= 8'h00;
			wstrb0_reg    <= 1'b0;
		end else begin
			s_axi_awready <= !aw_held_reg && !(s_axi_awvalid && s_axi_awready);
			s_axi_wready  <= !w_held_reg && !(s_axi_wvalid && s_axi_wready);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg <= 1'b1;
				awaddr_reg  <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_held_reg <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg <= 1'b1;
				wdata_reg  <= s_axi_wdata[7:0];
				wstrb0_reg <= s_axi_wstrb[0];
			end else if (wr_fire) begin
				w_held_reg <= 1'b0;
			end
		end
	end

	// Write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= MSC_RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (awaddr_reg == MSC_ADDR_SYS_CTRL
				|| awaddr_reg == MSC_ADDR_MODE_STATUS) ? MSC_RESP_OKAY : MSC_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// System control register; mode status ignores writes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sys_ctrl_reg <= MSC_SC_RESET;
		end else if (wr_fire && wstrb0_reg && awaddr_reg == MSC_ADDR_SYS_CTRL) begin
			sys_ctrl_reg <= (wdata_reg & MSC_SC_WR_MASK)
				| (MSC_SC_RESET & ~MSC_SC_WR_MASK);
		end
	end

	// Read channel, pins latched on a mode status read
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready  <= 1'b0;
			s_axi_rvalid   <= 1'b0;
			s_axi_rdata    <= 32'h0000_0000;
			s_axi_rresp    <= MSC_RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= MSC_RESP_OKAY;
				if (s_axi_araddr == MSC_ADDR_MODE_STATUS) begin
					s_axi_rdata <= {24'h000000, MSC_MS_FIXED | {6'h00, mode_sync2_reg}};
				end else if (s_axi_araddr == MSC_ADDR_SYS_CTRL) begin
					s_axi_rdata <= {24'h000000, sys_ctrl_reg};
				end else begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= MSC_RESP_SLVERR;
				end
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Control outputs driven from register bits and exc_start; set_mask_flag from exc_start alone
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ram_map_en        <= 1'b1;
			user_flag_is_mask <= 1'b0;
			set_mask_flag     <= 1'b0;
			set_user_flag     <= 1'b0;
		end else begin
			ram_map_en        <= sys_ctrl_reg[MSC_SC_RAM_BIT];
			user_flag_is_mask <= !sys_ctrl_reg[MSC_SC_USER_EN_BIT];
			set_mask_flag     <= exc_start;
			set_user_flag     <= exc_start && !sys_ctrl_reg[MSC_SC_USER_EN_BIT];
		end
	end

	// Nmi edge detect per edge select
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			nmi_request <= 1'b0;
		end else begin
			nmi_request <= sys_ctrl_reg[MSC_SC_NMI_EDGE_BIT]
				? (nmi_sync_reg[1] && !nmi_sync_reg[2])
				: (!nmi_sync_reg[1] && nmi_sync_reg[2]);
		end
	end

	// Power state transitions
	always_comb begin
		pwr_next = pwr_reg;
		case (pwr_reg)
			MSC_RUN: begin
				if (halt_insn) begin
					pwr_next = sys_ctrl_reg[MSC_SC_STANDBY_BIT] ? MSC_STANDBY : MSC_SLEEP;
				end
			end
			MSC_SLEEP: begin
				if (wake_irq) begin
					pwr_next = MSC_RUN;
				end
			end
			MSC_STANDBY: begin
				if (wake_irq) begin
					pwr_next = MSC_SETTLE;
				end
			end
			MSC_SETTLE: begin
				if (settle_done) begin
					pwr_next = MSC_RUN;
				end
			end
			default: pwr_next = MSC_RUN;
		endcase
	end

	// Power state and its outputs; standby leaves the register alone
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pwr_reg          <= MSC_RUN;
			settle_start_reg <= 1'b0;
			sleep_active     <= 1'b0;
			standby_active   <= 1'b0;
			clock_settled    <= 1'b0;
		end else begin
			pwr_reg          <= pwr_next;
			settle_start_reg <= (pwr_reg == MSC_STANDBY) && wake_irq;
			sleep_active     <= (pwr_next == MSC_SLEEP);
			standby_active   <= (pwr_next == MSC_STANDBY) || (pwr_next == MSC_SETTLE);
			clock_settled    <= settle_done;
		end
	end

	msc_settle_timer #(
		.CNT0 (SETTLE_0),
		.CNT1 (SETTLE_1),
		.CNT2 (SETTLE_2),
		.CNT3 (SETTLE_3),
		.CNT4 (SETTLE_4)
	) u_settle (
		.aclk    (aclk),
		.aresetn (aresetn),
		.start   (settle_start_reg),
		.sel     (sys_ctrl_reg[MSC_SC_SETTLE_HI:MSC_SC_SETTLE_LO]),
		.done    (settle_done)
	);

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Rule checks
	mode_fixed_bits_a: assert property (
		s_axi_arvalid && s_axi_arready && s_axi_araddr == MSC_ADDR_MODE_STATUS
		|=> s_axi_rdata[7:2] == 6'h30 && s_axi_rdata[1:0] == $past(mode_sync2_reg))
		else $error("mode status fixed bits wrong");
	mode_read_only_a: assert property (
		wr_fire && awaddr_reg == MSC_ADDR_MODE_STATUS |=> $stable(sys_ctrl_reg))
		else $error("mode status write changed state");
	rsvd_bit_one_a: assert property (
		sys_ctrl_reg[MSC_SC_RSVD_BIT] == 1'b1)
		else $error("reserved control bit not one");
	halt_select_a: assert property (
		pwr_reg == MSC_RUN && halt_insn |=> ($past(sys_ctrl_reg[MSC_SC_STANDBY_BIT])
		? pwr_reg == MSC_STANDBY : pwr_reg == MSC_SLEEP))
		else $error("halt went to wrong state");
	standby_bit_kept_a: assert property (
		pwr_reg == MSC_SETTLE && settle_done |=> sys_ctrl_reg[MSC_SC_STANDBY_BIT])
		else $error("standby select lost on exit");
	ram_reset_one_a: assert property (
		$rose(aresetn) |-> sys_ctrl_reg[MSC_SC_RAM_BIT])
		else $error("ram enable not set after reset");
	ram_map_follow_a: assert property (
		##1 ram_map_en == $past(sys_ctrl_reg[MSC_SC_RAM_BIT]))
		else $error("ram map not following enable");
	addr_pins_a: assert property (
		mode_sync2_reg == 2'b11 [*2] |-> addr_pin_en == MSC_PINS_16M)
		else $error("address pins wrong for mode");
	exc_flags_a: assert property (
		exc_start |=> set_mask_flag
		&& (set_user_flag == !$past(sys_ctrl_reg[MSC_SC_USER_EN_BIT])))
		else $error("exception flag setting wrong");
	nmi_edge_a: assert property (
		!sys_ctrl_reg[MSC_SC_NMI_EDGE_BIT] && $fell(nmi_sync_reg[1]) |=> nmi_request)
		else $error("falling nmi edge missed");
	settle_min_a: assert property (
		settle_start_reg |=> !settle_done [*8])
		else $error("settling ended too early");
	ctrl_write_a: assert property (
		wr_fire && wstrb0_reg && awaddr_reg == MSC_ADDR_SYS_CTRL
		|=> sys_ctrl_reg == (($past(wdata_reg) & MSC_SC_WR_MASK) | 8'h02))
		else $error("control write not applied");
	mode_1m_pins_a: assert property (
		mode_sync2_reg == 2'b01 [*2] |-> addr_pin_en == MSC_PINS_1M && !mode_16m)
		else $error("address pins wrong for small mode");
	mode_16m_flag_a: assert property (
		mode_sync2_reg == 2'b11 [*2] |-> mode_16m)
		else $error("large mode not flagged");
	user_mask_a: assert property (
		##1 user_flag_is_mask == !$past(sys_ctrl_reg[MSC_SC_USER_EN_BIT]))
		else $error("user flag role not following enable");
	nmi_rise_a: assert property (
		sys_ctrl_reg[MSC_SC_NMI_EDGE_BIT] && $rose(nmi_sync_reg[1]) |=> nmi_request)
		else $error("rising nmi edge missed");
	power_out_a: assert property (
		sleep_active == (pwr_reg == MSC_SLEEP)
		&& standby_active == (pwr_reg == MSC_STANDBY || pwr_reg == MSC_SETTLE))
		else $error("power outputs disagree with state");

	// Main scenarios reached
	standby_cycle_c: cover property (pwr_reg == MSC_SETTLE ##1 pwr_reg == MSC_SETTLE [*3]);
	sleep_cycle_c: cover property (pwr_reg == MSC_SLEEP ##[1:20] pwr_reg == MSC_RUN);
	mode_read_c: cover property (s_axi_rvalid && s_axi_rdata[1:0] == 2'b11);
	nmi_pulse_c: cover property (nmi_request);
endmodule

// ### msc_strap_model.sv
`timescale 1ns/1ps
// Board straps on the two mode pins, only the two legal patterns
module msc_strap_model (
	input  wire logic sel_16m,
	output logic      mode_pin_high,
	output logic      mode_pin_low
);
	// Low pin tied high, high pin picks 1 or 16 Mbyte; changed only under reset
	assign mode_pin_low  = 1'b1;
	assign mode_pin_high = sel_16m;
endmodule

// ### msc_top_tb.sv
`timescale 1ns/1ps
module msc_top_tb import msc_pkg::*;;
	localparam int SW [6] = '{16, 20, 24, 28, 32, 32};
	logic              aclk, aresetn, sel_16m, mph, mpl, nmi_pin;
	logic [19:0]       awaddr, araddr;
	logic              awvalid, awready, wvalid, wready, bvalid, bready;
	logic              arvalid, arready, rvalid, rready;
	logic [31:0]       wdata, rdata;
	logic [3:0]        wstrb;
	logic [1:0]        bresp, rresp;
	logic [2:0]        ev;
	logic              m16, ram_en, nmi_req, uf_mask, set_mask, set_user;
	logic              sleep_a, stby_a, settled;
	logic [23:0]       pins_en;
	int                errors, n_tests, cycles;

	msc_strap_model msc_strap_model_inst (.sel_16m(sel_16m), .mode_pin_high(mph),
		.mode_pin_low(mpl));
	msc_top #(.SETTLE_0(16), .SETTLE_1(20), .SETTLE_2(24), .SETTLE_3(28), .SETTLE_4(32))
	msc_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .mode_pin_high(mph), .mode_pin_low(mpl),
		.nmi_pin(nmi_pin), .halt_insn(ev[0]), .wake_irq(ev[1]), .exc_start(ev[2]),
		.mode_16m(m16), .addr_pin_en(pins_en), .ram_map_en(ram_en),
		.nmi_request(nmi_req), .user_flag_is_mask(uf_mask), .set_mask_flag(set_mask),
		.set_user_flag(set_user), .sleep_active(sleep_a), .standby_active(stby_a),
		.clock_settled(settled));

	// Clock at 100 ns
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	// Hang guard
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errors++;
			stop_test();
		end
	end

	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("unexpected %s: expected %h seen %h", nm, exp, got);
		end
	endtask

	task stop_test;
		$display("checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Write one byte; address and data offered together, each dropped when taken
	task axi_wr(input logic [19:0] a, input logic [7:0] d, output logic [1:0] r);
		@(posedge aclk);
		awaddr  <= a;
		awvalid <= 1'b1;
		wdata   <= {24'h000000, d};
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask

	task axi_rd(input logic [19:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	// One-cycle pulse on halt, wake or exception; returns at the sampling edge
	task pulse(input logic [2:0] v);
		@(posedge aclk);
		ev <= v;
		@(posedge aclk);
		ev <= 3'h0;
	endtask

	task do_reset(input logic big);
		aresetn <= 1'b0;
		sel_16m <= big;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (4) @(posedge aclk);
	endtask

	task t_reset_mode(input logic big);
		logic [31:0] d;
		logic [1:0]  r;
		do_reset(big);
		chk("mode_16m", {31'h0, big}, {31'h0, m16});
		chk("addr_pin_en", big ? 32'h00FFFFFF : 32'h000FFFFF, {8'h00, pins_en});
		chk("ram_map_en", 32'h1, {31'h0, ram_en});
		axi_rd(MSC_ADDR_SYS_CTRL, d, r);
		chk("sys_ctrl reset", 32'h0000000B, d);
		axi_wr(MSC_ADDR_MODE_STATUS, 8'h00, r);
		chk("status write resp", {30'h0, MSC_RESP_OKAY}, {30'h0, r});
		axi_rd(MSC_ADDR_MODE_STATUS, d, r);
		chk("mode status", {24'h0, 6'h30, big, 1'b1}, d);
		$display("test reset_mode done");
	endtask

	task t_ctrl_write;
		logic [31:0] d;
		logic [1:0]  r;
		axi_wr(MSC_ADDR_SYS_CTRL, 8'h00, r);
		axi_rd(MSC_ADDR_SYS_CTRL, d, r);
		chk("sys_ctrl zero", 32'h00000002, d);
		chk("ram_map_en off", 32'h0, {31'h0, ram_en});
		chk("user flag mask", 32'h1, {31'h0, uf_mask});
		axi_wr(MSC_ADDR_SYS_CTRL, 8'hDC, r);
		axi_rd(MSC_ADDR_SYS_CTRL, d, r);
		chk("sys_ctrl set", 32'h000000DE, d);
		chk("user flag plain", 32'h0, {31'h0, uf_mask});
		axi_rd(20'h00010, d, r);
		chk("unmapped resp", {30'h0, MSC_RESP_SLVERR}, {30'h0, r});
		chk("unmapped data", 32'h0, d);
		axi_wr(MSC_ADDR_SYS_CTRL, 8'h0B, r);
		@(posedge aclk);
		chk("ram_map_en on", 32'h1, {31'h0, ram_en});
		wstrb <= 4'hE;
		axi_wr(MSC_ADDR_SYS_CTRL, 8'h00, r);
		wstrb <= 4'hF;
		chk("masked write resp", {30'h0, MSC_RESP_OKAY}, {30'h0, r});
		axi_rd(MSC_ADDR_SYS_CTRL, d, r);
		chk("sys_ctrl masked", 32'h0000000B, d);
		$display("test ctrl_write done");
	endtask

	task t_exc;
		logic [1:0] r;
		for (int ue = 1; ue >= 0; ue--) begin
			axi_wr(MSC_ADDR_SYS_CTRL, {4'h0, ue[0], 3'h3}, r);
			pulse(3'h4);
			@(posedge aclk);
			chk("set_mask_flag", 32'h1, {31'h0, set_mask});
			chk("set_user_flag", {31'h0, ~ue[0]}, {31'h0, set_user});
		end
		$display("test exception done");
	endtask

	// Move the nmi pin and count requests over the following cycles
	task nmi_step(input logic v, input int exp);
		int n;
		n = 0;
		@(posedge aclk);
		nmi_pin <= v;
		repeat (8) begin
			@(posedge aclk);
			n += int'(nmi_req === 1'b1);
		end
		chk("nmi requests", exp, n);
	endtask

	task t_nmi;
		logic [1:0] r;
		axi_wr(MSC_ADDR_SYS_CTRL, 8'h0B, r);
		nmi_step(1'b0, 1);
		nmi_step(1'b1, 0);
		axi_wr(MSC_ADDR_SYS_CTRL, 8'h0F, r);
		nmi_step(1'b0, 0);
		nmi_step(1'b1, 1);
		$display("test nmi done");
	endtask

	task t_power;
		logic [31:0] d;
		logic [1:0]  r;
		int          k;
		axi_wr(MSC_ADDR_SYS_CTRL, 8'h0B, r);
		pulse(3'h1);
		@(posedge aclk);
		chk("sleep entry", 32'h1, {30'h0, stby_a, sleep_a});
		pulse(3'h2);
		repeat (2) @(posedge aclk);
		chk("sleep exit", 32'h0, {31'h0, sleep_a});
		for (int s = 0; s < 6; s++) begin
			axi_wr(MSC_ADDR_SYS_CTRL, {1'b1, s[2:0], 4'h9}, r);
			pulse(3'h1);
			@(posedge aclk);
			chk("standby entry", 32'h2, {30'h0, stby_a, sleep_a});
			pulse(3'h2);
			k = 0;
			do begin
				@(posedge aclk);
				k++;
			end while (settled !== 1'b1 && k < 200);
			chk("settle wait", SW[s] + 3, k);
			chk("standby left", 32'h0, {31'h0, stby_a});
			axi_rd(MSC_ADDR_SYS_CTRL, d, r);
			chk("ctrl after standby", {24'h0, 1'b1, s[2:0], 4'hB}, d);
		end
		$display("test power done");
	endtask

	initial begin
		{errors, n_tests, cycles} = '0;
		{awaddr, araddr, awvalid, wvalid, bready, arvalid, rready} = '0;
		{wdata, ev, sel_16m} = '0;
		{aresetn, nmi_pin} = 2'h1;
		wstrb = 4'hF;
		t_reset_mode(1'b0);
		t_ctrl_write();
		t_exc();
		t_nmi();
		t_power();
		t_reset_mode(1'b1);
		stop_test();
	end
endmodule
